/* src/sio_pkg.sv */
package sio_pkg;

    // =====================================================================
    // Register offsets
    localparam logic [7:0] OFS_IN_SET   = 8'h30;
    localparam logic [7:0] OFS_OUT_SET  = 8'h50;
    localparam logic [7:0] OFS_L_HIGH   = 8'h51;
    localparam logic [7:0] OFS_L_MID    = 8'h52;
    localparam logic [7:0] OFS_L_LOW    = 8'h53;
    localparam logic [7:0] OFS_R_HIGH   = 8'h54;
    localparam logic [7:0] OFS_R_MID    = 8'h55;
    localparam logic [7:0] OFS_R_LOW    = 8'h56;

    // =====================================================================
    // Field positions
    localparam int BIT_RX_PON    = 4;
    localparam int BIT_TX_VALID  = 8;
    localparam int BIT_TX_COPY   = 6;
    localparam int BIT_TX_PON    = 4;
    localparam int BIT_TX_DIS    = 3;

    // =====================================================================
    // Reset values
    localparam logic [15:0] RST_IN_SET  = 16'h0010;
    localparam logic [15:0] RST_OUT_SET = 16'h0054;
    localparam logic [15:0] RST_STATUS  = 16'h0000;
    // Writable bit masks; reserved bits stay zero
    localparam logic [15:0] MSK_IN_SET  = 16'h0013;
    localparam logic [15:0] MSK_OUT_SET = 16'h015f;
    localparam logic [15:0] MSK_LOW     = 16'h00ff;

    // =====================================================================
    // Source codes and sampling frequency codes
    localparam logic [2:0] SRC_ADC     = 3'h0;
    localparam logic [2:0] SRC_SERIAL  = 3'h1;
    localparam logic [2:0] SRC_UNUSED  = 3'h2;
    localparam logic [2:0] SRC_MIX     = 3'h3;
    localparam logic [3:0] FS_44K1     = 4'h0;
    localparam logic [3:0] FS_48K      = 4'h1;
    localparam logic [3:0] FS_32K      = 4'h2;

    typedef enum logic [1:0] {
        SIO_FS_44K1,
        SIO_FS_48K,
        SIO_FS_32K,
        SIO_FS_RSVD
    } sio_fs_t;

    // Transmit control bundle
    typedef struct packed {
        logic       validity;
        logic       power_on;
        logic       encoder_disable;
        logic [2:0] source;
    } sio_tx_ctrl_t;

endpackage

/* src/sio_regs.sv */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// =====================================================================
// Behaviour
// - Receive path powered down when bit is 0
// - Two-bit selector routes one of four pins
// - Validity bit marks transmitted samples valid
// - Copy bit sends left status on right
// - Transmit path powered down when bit is 0
// - Encoder disable bit stops the encoder
// - Three-bit selector picks encoder source
// - Upper registers give status bits 39..24
// - Middle registers give status bits 23..8
// - Low byte gives bits 7..0, upper reserved
// - Left status bits 27..24 decode sampling frequency
module sio_regs (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_reset,
    input  wire logic [7:0]            i_addr,
    input  wire logic [15:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [15:0]           o_rdata,
    input  wire logic [3:0]            i_rx_pin,
    input  wire logic                  i_block_start,
    output logic                       o_rx_power_on,
    output logic                       o_rx_slicer_in,
    output logic      [1:0]            o_rx_pin_select,
    output sio_pkg::sio_tx_ctrl_t      o_tx_ctrl,
    output logic                       o_tx_loop_in,
    output logic                       o_tx_src_unused,
    output logic      [39:0]           o_tx_status_left,
    output logic      [39:0]           o_tx_status_right,
    output sio_pkg::sio_fs_t           o_tx_fs
);

    // =====================================================================
    // Register storage
    logic [15:0] in_set_reg;
    logic [15:0] out_set_reg;
    logic [39:0] stat_l_reg;
    logic [39:0] stat_r_reg;
    logic [39:0] act_l_reg;
    logic [39:0] act_r_reg;
    logic [39:0] act_r_next;
    logic [3:0]  pin_s1_reg;
    logic [3:0]  pin_s2_reg;
    logic [15:0] rdata_next;

    // Forty-bit reset image built from the 16-bit package value
    localparam logic [39:0] STAT_RST = {sio_pkg::RST_STATUS[7:0],
                                        sio_pkg::RST_STATUS,
                                        sio_pkg::RST_STATUS};

    // Input settings register; reserved bits forced low
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            in_set_reg <= sio_pkg::RST_IN_SET;
        end else if (i_wr && i_addr == sio_pkg::OFS_IN_SET) begin
            in_set_reg <= i_wdata & sio_pkg::MSK_IN_SET;
        end
    end

    // Output settings register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            out_set_reg <= sio_pkg::RST_OUT_SET;
        end else if (i_wr && i_addr == sio_pkg::OFS_OUT_SET) begin
            out_set_reg <= i_wdata & sio_pkg::MSK_OUT_SET;
        end
    end

    // Shadow status words, as software sees them
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            stat_l_reg <= STAT_RST;
            stat_r_reg <= STAT_RST;
        end else if (i_wr) begin
            case (i_addr)
                sio_pkg::OFS_L_HIGH: stat_l_reg[39:24] <= i_wdata;
                sio_pkg::OFS_L_MID:  stat_l_reg[23:8]  <= i_wdata;
                sio_pkg::OFS_L_LOW:
                    stat_l_reg[7:0] <= i_wdata[7:0];
                sio_pkg::OFS_R_HIGH: stat_r_reg[39:24] <= i_wdata;
                sio_pkg::OFS_R_MID:  stat_r_reg[23:8]  <= i_wdata;
                sio_pkg::OFS_R_LOW:
                    stat_r_reg[7:0] <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Right channel takes left status while copy is set
    always_comb begin
        act_r_next = out_set_reg[sio_pkg::BIT_TX_COPY]
                   ? stat_l_reg : stat_r_reg;
    end

    // Active status only moves at a block boundary, so one block
    // never mixes old and new bits; costs a block of latency
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            act_l_reg <= STAT_RST;
            act_r_reg <= STAT_RST;
        end else if (i_block_start) begin
            act_l_reg <= stat_l_reg;
            act_r_reg <= act_r_next;
        end
    end

    // Pins are asynchronous: two flops before use
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
        end else begin
            pin_s1_reg <= i_rx_pin;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // =====================================================================
    // Read path, data valid the cycle after the strobe
    always_comb begin
        case (i_addr)
            sio_pkg::OFS_IN_SET:  rdata_next = in_set_reg;
            sio_pkg::OFS_OUT_SET: rdata_next = out_set_reg;
            sio_pkg::OFS_L_HIGH:  rdata_next = stat_l_reg[39:24];
            sio_pkg::OFS_L_MID:   rdata_next = stat_l_reg[23:8];
            sio_pkg::OFS_L_LOW:   rdata_next = {8'h00, stat_l_reg[7:0]};
            sio_pkg::OFS_R_HIGH:  rdata_next = stat_r_reg[39:24];
            sio_pkg::OFS_R_MID:   rdata_next = stat_r_reg[23:8];
            sio_pkg::OFS_R_LOW:   rdata_next = {8'h00, stat_r_reg[7:0]};
            default:              rdata_next = 16'h0000; // Unmapped reads zero
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // =====================================================================
    // Control outputs
    assign o_rx_power_on   = in_set_reg[sio_pkg::BIT_RX_PON];
    assign o_rx_pin_select = in_set_reg[1:0];
    // Slicer sees the selected pin, held low while powered down
    assign o_rx_slicer_in  = o_rx_power_on
                           & pin_s2_reg[in_set_reg[1:0]];

    assign o_tx_ctrl.validity        =
        out_set_reg[sio_pkg::BIT_TX_VALID];
    assign o_tx_ctrl.power_on        =
        out_set_reg[sio_pkg::BIT_TX_PON];
    assign o_tx_ctrl.encoder_disable =
        out_set_reg[sio_pkg::BIT_TX_DIS] | ~o_tx_ctrl.power_on;
    assign o_tx_ctrl.source          = out_set_reg[2:0];
    // Loop-through codes carry the pin number in the low two bits
    assign o_tx_loop_in    = out_set_reg[2]
                           & pin_s2_reg[out_set_reg[1:0]];
    assign o_tx_src_unused = out_set_reg[2:0] == sio_pkg::SRC_UNUSED;

    assign o_tx_status_left  = act_l_reg;
    assign o_tx_status_right = act_r_reg;

    // Sampling frequency decode from left status bits 27..24
    always_comb begin
        case (act_l_reg[27:24])
            sio_pkg::FS_44K1: o_tx_fs = sio_pkg::SIO_FS_44K1;
            sio_pkg::FS_48K:  o_tx_fs = sio_pkg::SIO_FS_48K;
            sio_pkg::FS_32K:  o_tx_fs = sio_pkg::SIO_FS_32K;
            default:          o_tx_fs = sio_pkg::SIO_FS_RSVD;
        endcase
    end

    // =====================================================================
    // Checks
    // All checks share the system clock and sleep through reset
    default clocking chk_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    // Receive power output is the register bit itself
    chk_rx_power_bit: assert property (
        o_rx_power_on == in_set_reg[sio_pkg::BIT_RX_PON])
        else $error("rx power bit mismatch");

    // Powered-down receiver must not pass pin activity on
    chk_slicer_off: assert property (
        !o_rx_power_on |-> !o_rx_slicer_in)
        else $error("slicer active in power down");

    // Slicer follows the synchronised pin that the selector names
    chk_slicer_route: assert property (
        o_rx_power_on
        |-> o_rx_slicer_in == pin_s2_reg[o_rx_pin_select])
        else $error("slicer routing wrong");

    // A write to the input settings lands on the next edge
    chk_rx_write_bit: assert property (
        (i_wr && i_addr == sio_pkg::OFS_IN_SET)
        |=> o_rx_power_on == $past(i_wdata[sio_pkg::BIT_RX_PON]))
        else $error("rx power write lost");

    // Validity flag takes the written bit on the next edge
    chk_valid_write: assert property (
        (i_wr && i_addr == sio_pkg::OFS_OUT_SET)
        |=> o_tx_ctrl.validity == $past(i_wdata[sio_pkg::BIT_TX_VALID]))
        else $error("validity write lost");

    // Transmit power flag takes the written bit on the next edge
    chk_tx_power_write: assert property (
        (i_wr && i_addr == sio_pkg::OFS_OUT_SET)
        |=> o_tx_ctrl.power_on == $past(i_wdata[sio_pkg::BIT_TX_PON]))
        else $error("tx power write lost");

    // With copy set, right channel loads the left shadow
    chk_copy_left: assert property (
        (i_block_start && out_set_reg[sio_pkg::BIT_TX_COPY])
        |=> act_r_reg == $past(stat_l_reg))
        else $error("status copy failed");

    // With copy clear, right channel keeps its own shadow
    chk_copy_off: assert property (
        (i_block_start && !out_set_reg[sio_pkg::BIT_TX_COPY])
        |=> act_r_reg == $past(stat_r_reg))
        else $error("right status not own");

    // A powered-down transmitter never runs its encoder
    chk_tx_power_dis: assert property (
        !o_tx_ctrl.power_on |-> o_tx_ctrl.encoder_disable)
        else $error("encoder runs while powered down");

    // Encoder stops on the disable bit or on power down
    chk_enc_disable: assert property (
        o_tx_ctrl.encoder_disable
        == (out_set_reg[sio_pkg::BIT_TX_DIS]
            | ~out_set_reg[sio_pkg::BIT_TX_PON]))
        else $error("encoder disable wrong");

    // Loop-through codes pick the synchronised pin
    chk_loop_route: assert property (
        o_tx_ctrl.source[2]
        |-> o_tx_loop_in == pin_s2_reg[o_tx_ctrl.source[1:0]])
        else $error("loop-through wrong");

    // Other sources leave the loop-through path quiet
    chk_loop_idle: assert property (
        !o_tx_ctrl.source[2] |-> !o_tx_loop_in)
        else $error("loop-through active off code");

    // The unused code is flagged and nothing else is
    chk_unused_code: assert property (
        o_tx_src_unused == (o_tx_ctrl.source == sio_pkg::SRC_UNUSED))
        else $error("unused source flag wrong");

    // Upper left shadow takes the written word
    chk_high_write: assert property (
        (i_wr && i_addr == sio_pkg::OFS_L_HIGH)
        |=> stat_l_reg[39:24] == $past(i_wdata))
        else $error("high status write lost");

    // Middle left shadow reaches the active copy at a boundary
    chk_mid_apply: assert property (
        i_block_start
        |=> act_l_reg[23:8] == $past(stat_l_reg[23:8]))
        else $error("mid status not applied");

    // Reserved upper byte of the low registers reads zero
    chk_low_reserved: assert property (
        $past(i_rd) && ($past(i_addr) == sio_pkg::OFS_L_LOW
                        || $past(i_addr) == sio_pkg::OFS_R_LOW)
        |-> o_rdata[15:8] == 8'h00)
        else $error("reserved byte not zero");

    // Read data stand only one cycle, then the bus returns to zero
    chk_rdata_idle: assert property (
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data held too long");

    // Code one in the frequency field decodes as 48 kHz
    chk_fs_decode: assert property (
        act_l_reg[27:24] == sio_pkg::FS_48K
        |-> o_tx_fs == sio_pkg::SIO_FS_48K)
        else $error("fs decode wrong");

    // Left active status only moves at a block boundary
    chk_hold_block: assert property (
        !i_block_start |=> $stable(act_l_reg))
        else $error("status changed mid block");

    // Right active status only moves at a block boundary
    chk_hold_right: assert property (
        !i_block_start |=> $stable(act_r_reg))
        else $error("right status changed mid block");

    // Main scenarios that the bench should reach
    cov_block_load: cover property (i_block_start);
    cov_copy_off: cover property (
        i_block_start && !out_set_reg[sio_pkg::BIT_TX_COPY]);
    cov_loop_src: cover property (out_set_reg[2]);
    cov_rx_down: cover property (!o_rx_power_on);
    cov_low_read: cover property (i_rd && i_addr == sio_pkg::OFS_L_LOW);

endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic                  i_clk_sys, i_reset, i_wr, i_rd, i_block_start;
    logic [7:0]            i_addr;
    logic [15:0]           i_wdata;
    logic [3:0]            i_rx_pin;
    logic [15:0]           o_rdata;
    logic                  o_rx_power_on, o_rx_slicer_in, o_tx_loop_in;
    logic                  o_tx_src_unused;
    logic [1:0]            o_rx_pin_select;
    sio_pkg::sio_tx_ctrl_t o_tx_ctrl;
    logic [39:0]           o_tx_status_left, o_tx_status_right;
    sio_pkg::sio_fs_t      o_tx_fs;
    int                    err_total = 0;
    int                    tests_run = 0;

    sio_regs dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_pin(i_rx_pin), .i_block_start(i_block_start),
        .o_rx_power_on(o_rx_power_on), .o_rx_slicer_in(o_rx_slicer_in),
        .o_rx_pin_select(o_rx_pin_select), .o_tx_ctrl(o_tx_ctrl),
        .o_tx_loop_in(o_tx_loop_in), .o_tx_src_unused(o_tx_src_unused),
        .o_tx_status_left(o_tx_status_left),
        .o_tx_status_right(o_tx_status_right), .o_tx_fs(o_tx_fs));

    // =====================================================================
    // Clock and bus helpers
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    // Strobe for one cycle; the trailing delay lets register updates land
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
                      input string m);
        @(posedge i_clk_sys);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk({24'h0, o_rdata}, {24'h0, e}, m);
    endtask

    task automatic blk();
        @(posedge i_clk_sys);
        i_block_start <= 1'b1;
        @(posedge i_clk_sys);
        i_block_start <= 1'b0;
        #1;
    endtask

    // Pins pass two synchroniser flops, so give them three edges
    task automatic pins(input logic [3:0] p);
        @(posedge i_clk_sys);
        i_rx_pin <= p;
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset();
        chk({39'h0, o_rx_power_on}, 40'h1, "rx power reset");
        chk({39'h0, o_tx_ctrl.power_on}, 40'h1, "tx power reset");
        chk({39'h0, o_tx_ctrl.encoder_disable}, 40'h0, "enc rst");
        chk({39'h0, o_tx_ctrl.validity}, 40'h0, "valid reset");
        chk({37'h0, o_tx_ctrl.source}, 40'h4, "source reset");
        rd(8'h30, 16'h0010, "in settings reset");
        rd(8'h50, 16'h0054, "out settings reset");
        rd(8'h53, 16'h0000, "status low reset");
        $display("test reset done");
    endtask

    task automatic t_rx();
        for (int s = 0; s < 4; s++) begin
            wr(8'h30, 16'h0010 | 16'(s));
            pins(4'h1 << s);
            chk({38'h0, o_rx_pin_select}, 40'(s), "pin select");
            chk({39'h0, o_rx_slicer_in}, 40'h1, "slicer high");
            pins(~(4'h1 << s));
            chk({39'h0, o_rx_slicer_in}, 40'h0, "slicer low");
        end
        wr(8'h30, 16'hffff);
        rd(8'h30, 16'h0013, "in reserved bits");
        pins(4'hf);
        wr(8'h30, 16'h0000);
        chk({39'h0, o_rx_power_on}, 40'h0, "rx power down");
        chk({39'h0, o_rx_slicer_in}, 40'h0, "slicer off");
        $display("test receive done");
    endtask

    task automatic t_tx();
        logic [2:0] c;
        pins(4'h5);
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            wr(8'h50, 16'h0010 | 16'(k));
            chk({37'h0, o_tx_ctrl.source}, 40'(k), "source");
            chk({39'h0, o_tx_src_unused}, 40'(c==3'h2), "spare");
            chk({39'h0, o_tx_loop_in}, 40'(c[2]&~c[0]), "loop");
        end
        wr(8'h50, 16'h0110);
        chk({39'h0, o_tx_ctrl.validity}, 40'h1, "valid set");
        chk({39'h0, o_tx_ctrl.encoder_disable}, 40'h0, "enc run");
        wr(8'h50, 16'h0018);
        chk({39'h0, o_tx_ctrl.validity}, 40'h0, "valid clear");
        chk({39'h0, o_tx_ctrl.encoder_disable}, 40'h1, "enc off");
        wr(8'h50, 16'h0000);
        chk({39'h0, o_tx_ctrl.power_on}, 40'h0, "tx power down");
        wr(8'h50, 16'hffff);
        rd(8'h50, 16'h015f, "out reserved bits");
        $display("test transmit done");
    endtask

    task automatic t_status();
        logic [3:0] nib [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
        wr(8'h50, 16'h0014);
        wr(8'h51, 16'ha1b2); wr(8'h52, 16'hc3d4); wr(8'h53, 16'hffe5);
        wr(8'h54, 16'h1234); wr(8'h55, 16'h5678); wr(8'h56, 16'h009a);
        rd(8'h53, 16'h00e5, "low reserved byte");
        chk(o_tx_status_left, 40'h0, "held until boundary");
        blk();
        chk(o_tx_status_left, 40'ha1b2c3d4e5, "left status");
        chk(o_tx_status_right, 40'h123456789a, "right status");
        for (int k = 0; k < 4; k++) begin
            wr(8'h51, {12'ha1b, nib[k]});
            blk();
            chk({38'h0, o_tx_fs}, 40'(k), "fs decode");
        end
        wr(8'h50, 16'h0054);
        blk();
        chk(o_tx_status_right, 40'ha1b9c3d4e5, "copy left");
        wr(8'h40, 16'hbeef);
        rd(8'h40, 16'h0000, "unmapped read");
        rd(8'h56, 16'h009a, "right low kept");
        $display("test status done");
    endtask

    // =====================================================================
    // Verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        i_reset = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_block_start = 1'b0;
        i_addr = 8'h00; i_wdata = 16'h0000; i_rx_pin = 4'h0;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        #1;
        t_reset();
        t_rx();
        t_tx();
        t_status();
        report_and_stop();
    end
endmodule
